// File: logic/adcsf_status.sv
// How it works
// - Eight-bit status register at address zero, reset value 0x80.
// - With append enabled, status byte follows every data register read.
// - Chip select low and no read running: ready flag drives the output pin.
// - Ready flag bit 7, active low, cleared when a new result is written.
// - In calibration mode ready clears on calibration result, not conversion result.
// - Ready flag set again when a data register read completes; resets to one.
// - Bit 6 flags overrange or underrange of the latest conversion; resets to zero.
// - Overrange stores all ones, underrange stores all zeros.
// - Range flag updates only on result writes, clears once condition gone.
// - Bit 5 set on CRC mismatch of a register write; resets to zero.
// - A completed status register read clears the write CRC flag; a CRC error in the same cycle keeps it set.
// - Bit 4 set when register contents differ from the captured checksum.
// - Integrity flag clears only by dropping the enable, not by reads.
// - Bits 3..0 hold the channel of the result in the data register.
`timescale 1ns/1ps
module adcsf_status
   import adcsf_pkg::*;
(
   // Clock and reset
   input  wire logic                          clock,
   input  wire logic                          reset_n,
   // Serial link pins
   input  wire logic                          csN,
   input  wire logic                          sclk,
   input  wire logic                          din,
   output logic                               dout,
   output logic                               doutOe,
   // Conversion results
   input  wire logic                          resultValid,
   input  wire logic [adcsf_pkg::DATA_W-1:0]  resultData,
   input  wire logic [adcsf_pkg::CHAN_W-1:0]  resultChan,
   input  wire logic                          overRange,
   input  wire logic                          underRange,
   input  wire logic                          calibMode,
   input  wire logic                          calibDone,
   // Interface configuration and checks
   input  wire logic                          appendStatus,
   input  wire logic                          crcWriteErr,
   input  wire logic                          regCheckEn,
   input  wire logic                          regMismatch,
   // Register views
   output logic [adcsf_pkg::STAT_W-1:0]       statusOut,
   output logic [adcsf_pkg::DATA_W-1:0]       dataOut
);
   import adcsf_pkg::*;

   // ****************************************
   // Pin synchronisers and edges
   // ****************************************
   logic [2:0]        pinSync;
   logic              csActive;
   logic              sclkS;
   logic              dinS;
   logic              sclk_q;
   logic              sclkRise;
   logic              sclkFall;

   adcsf_sync #(.WIDTH(3)) u_sync (
      .clock   (clock),
      .reset_n (reset_n),
      .asyncIn ({~csN, sclk, din}),
      .syncOut (pinSync)
   );

   assign csActive = pinSync[2];
   assign sclkS    = pinSync[1];
   assign dinS     = pinSync[0];
   assign sclkRise = csActive & sclkS & ~sclk_q;
   assign sclkFall = csActive & ~sclkS & sclk_q;

   // Idle-high clock so the first falling edge after select is a real one
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         sclk_q <= 1'b1;
      end else begin
         sclk_q <= sclkS;
      end
   end

   // ****************************************
   // Serial transfer engine
   // ****************************************
   adcsf_xfer_t          xfer_q;
   logic [7:0]           cmd_q;
   logic [CNT_W-1:0]     count_q;
   logic [SHIFT_W-1:0]   shift_q;
   logic                 pend_q;
   logic                 readDone;
   logic                 dataReadDone;
   logic                 statReadDone;
   logic [5:0]           rdAddr_q;
   logic [7:0]           cmdByte;
   logic                 rdy_q;
   logic                 rangeErr_q;
   logic                 crcErr_q;
   logic                 regErr_q;
   logic [CHAN_W-1:0]    chan_q;
   logic [STAT_W-1:0]    statusNow;

   assign statusNow    = {rdy_q, rangeErr_q, crcErr_q, regErr_q, chan_q};
   assign cmdByte      = {cmd_q[6:0], dinS};
   assign readDone     = (xfer_q == XF_READ) && sclkRise && (count_q == 6'h01);
   assign dataReadDone = readDone && (rdAddr_q == ADDR_DATA);
   assign statReadDone = readDone && (rdAddr_q == ADDR_STATUS);

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         xfer_q   <= XF_CMD;
         cmd_q    <= '0;
         count_q  <= '0;
         shift_q  <= '0;
         pend_q   <= 1'b0;
         rdAddr_q <= '0;
      end else if (!csActive) begin
         xfer_q  <= XF_CMD;
         count_q <= '0;
         pend_q  <= 1'b0;
      end else begin
         unique case (xfer_q)
            XF_CMD: begin
               if (sclkRise) begin
                  cmd_q   <= cmdByte;
                  count_q <= (count_q == LEN_LAST) ? '0 : count_q + 6'h01;
                  if (count_q == LEN_LAST && !cmdByte[CMD_WEN]) begin
                     rdAddr_q <= cmdByte[CMD_ADDR_HI:0];
                     pend_q   <= 1'b0;
                     if (cmdByte[CMD_RW]) begin
                        xfer_q <= XF_READ;
                        if (cmdByte[CMD_ADDR_HI:0] == ADDR_DATA) begin
                           shift_q <= {dataOut, statusNow};
                           count_q <= appendStatus ? LEN_DSTAT : LEN_DATA;
                        end else if (cmdByte[CMD_ADDR_HI:0] == ADDR_STATUS) begin
                           shift_q <= {statusNow, CLAMP_LOW};
                           count_q <= LEN_BYTE;
                        end else begin
                           shift_q <= '0;
                           count_q <= LEN_BYTE;
                        end
                     end else begin
                        // Status is read-only: the write byte is clocked in and dropped
                        xfer_q  <= XF_WRITE;
                        count_q <= LEN_BYTE;
                     end
                  end
               end
            end
            XF_READ: begin
               // Shift only on the fall after a rise, so the host sees each bit a half period
               if (sclkRise) begin
                  pend_q  <= 1'b1;
                  count_q <= count_q - 6'h01;
                  if (count_q == 6'h01) begin
                     xfer_q <= XF_CMD;
                     pend_q <= 1'b0;
                  end
               end else if (sclkFall && pend_q) begin
                  shift_q <= {shift_q[SHIFT_W-2:0], 1'b0};
                  pend_q  <= 1'b0;
               end
            end
            XF_WRITE: begin
               if (sclkRise) begin
                  count_q <= count_q - 6'h01;
                  if (count_q == 6'h01) begin
                     xfer_q <= XF_CMD;
                  end
               end
            end
            default: begin
               xfer_q <= XF_CMD;
            end
         endcase
      end
   end

   // ****************************************
   // Output pin
   // ****************************************
   // Ready is shown one clock late; harmless against a 200 ns link clock
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         dout   <= 1'b1;
         doutOe <= 1'b0;
      end else begin
         doutOe <= csActive;
         dout   <= (xfer_q == XF_READ) ? shift_q[SHIFT_W-1] : rdy_q;
      end
   end

   // ****************************************
   // Result and ready flag
   // ****************************************
   logic newResult;
   assign newResult = calibMode ? calibDone : resultValid;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rdy_q <= STATUS_RST[ST_RDY];
      end else if (newResult) begin
         rdy_q <= 1'b0;
      end else if (dataReadDone) begin
         rdy_q <= 1'b1;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         dataOut    <= CLAMP_LOW;
         rangeErr_q <= STATUS_RST[ST_RANGE];
         chan_q     <= STATUS_RST[CHAN_W-1:0];
      end else if (resultValid) begin
         dataOut    <= overRange ? CLAMP_HIGH : underRange ? CLAMP_LOW : resultData;
         rangeErr_q <= overRange | underRange;
         chan_q     <= resultChan;
      end
   end

   // ****************************************
   // Error flags
   // ****************************************
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         crcErr_q <= STATUS_RST[ST_CRC];
      end else if (crcWriteErr) begin
         crcErr_q <= 1'b1;
      end else if (statReadDone) begin
         crcErr_q <= 1'b0;
      end
   end

   // Integrity flag is only ever cleared by the enable, never by a read
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         regErr_q <= STATUS_RST[ST_REG];
      end else if (!regCheckEn) begin
         regErr_q <= 1'b0;
      end else if (regMismatch) begin
         regErr_q <= 1'b1;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         statusOut <= STATUS_RST;
      end else begin
         statusOut <= statusNow;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   a_rdy_clears: assert property (@(posedge clock) disable iff (!reset_n)
      resultValid && !calibMode |=> !rdy_q ##1 (!statusOut[ST_RDY]))
      else $error("ready not cleared by result");
   a_cal_hold: assert property (@(posedge clock) disable iff (!reset_n)
      calibMode && !calibDone && rdy_q && !dataReadDone |=> rdy_q)
      else $error("ready cleared without calibration result");
   a_rdy_sets: assert property (@(posedge clock) disable iff (!reset_n)
      dataReadDone && !newResult |=> rdy_q)
      else $error("ready not set after data read");
   a_over_clamp: assert property (@(posedge clock) disable iff (!reset_n)
      resultValid && overRange |=> dataOut == CLAMP_HIGH && rangeErr_q)
      else $error("overrange not clamped");
   a_under_clamp: assert property (@(posedge clock) disable iff (!reset_n)
      resultValid && underRange && !overRange |=> dataOut == CLAMP_LOW && rangeErr_q)
      else $error("underrange not clamped");
   a_range_hold: assert property (@(posedge clock) disable iff (!reset_n)
      !resultValid |=> $stable(rangeErr_q) && $stable(chan_q))
      else $error("range flag moved without result");
   a_crc_flag: assert property (@(posedge clock) disable iff (!reset_n)
      crcWriteErr |=> crcErr_q ##1 statusOut[ST_CRC])
      else $error("CRC error not flagged");
   a_crc_clear: assert property (@(posedge clock) disable iff (!reset_n)
      statReadDone && !crcWriteErr |=> !crcErr_q)
      else $error("CRC flag survived status read");
   a_reg_clear: assert property (@(posedge clock) disable iff (!reset_n)
      !regCheckEn |=> !regErr_q)
      else $error("integrity flag not cleared by enable");
   a_reg_sticky: assert property (@(posedge clock) disable iff (!reset_n)
      regErr_q && regCheckEn |=> regErr_q)
      else $error("integrity flag lost while enabled");
   a_pin_ready: assert property (@(posedge clock) disable iff (!reset_n)
      csActive && xfer_q != XF_READ |=> dout == $past(rdy_q) && doutOe)
      else $error("ready not mirrored on pin");
   a_wr_ignored: assert property (@(posedge clock) disable iff (!reset_n)
      xfer_q == XF_WRITE && !resultValid && !crcWriteErr && !regMismatch && !regErr_q && !newResult
      |=> $stable(statusNow))
      else $error("status changed by write");

   c_data_read: cover property (@(posedge clock) disable iff (!reset_n) dataReadDone);
   c_append: cover property (@(posedge clock) disable iff (!reset_n)
      dataReadDone && appendStatus);
   c_stat_read: cover property (@(posedge clock) disable iff (!reset_n)
      statReadDone && crcErr_q);

endmodule : adcsf_status

// File: inc/adcsf_pkg.sv
// ****************************************
// Status block constants
// ****************************************
package adcsf_pkg;

   localparam int          DATA_W      = 24;
   localparam int          STAT_W      = 8;
   localparam int          CHAN_W      = 4;
   localparam int          SHIFT_W     = DATA_W + STAT_W;
   localparam int          CNT_W       = 6;

   // Register addresses carried in the command byte
   localparam logic [5:0]  ADDR_STATUS = 6'h00;
   localparam logic [5:0]  ADDR_DATA   = 6'h04;

   // Command byte fields
   localparam int          CMD_WEN     = 7;
   localparam int          CMD_RW      = 6;
   localparam int          CMD_ADDR_HI = 5;

   // Status register layout
   localparam int          ST_RDY      = 7;
   localparam int          ST_RANGE    = 6;
   localparam int          ST_CRC      = 5;
   localparam int          ST_REG      = 4;
   localparam logic [7:0]  STATUS_RST  = 8'h80;

   // Clamp values for out-of-range results
   localparam logic [23:0] CLAMP_HIGH  = 24'hFFFFFF;
   localparam logic [23:0] CLAMP_LOW   = 24'h000000;

   // Transfer lengths in bits
   localparam logic [5:0]  LEN_BYTE    = 6'h08;
   localparam logic [5:0]  LEN_DATA    = 6'h18;
   localparam logic [5:0]  LEN_DSTAT   = 6'h20;
   localparam logic [5:0]  LEN_LAST    = 6'h07;

   typedef enum logic [1:0] {
      XF_CMD,
      XF_READ,
      XF_WRITE
   } adcsf_xfer_t;

endpackage : adcsf_pkg

// File: logic/adcsf_sync.sv
`timescale 1ns/1ps
module adcsf_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             reset_n,
   // Asynchronous levels in, synchronised levels out
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);

   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         meta_q  <= '0;
         syncOut <= '0;
      end else begin
         meta_q  <= asyncIn;
         syncOut <= meta_q;
      end
   end

endmodule : adcsf_sync

// File: verif/adcsf_host.sv
`timescale 1ns/1ps
// ****************************************
// Host side of the serial link, mode 3
// ****************************************
module adcsf_host (
   // Clock used only to place the link phase
   input  wire logic clock,
   // Link pins
   output logic      csN,
   output logic      sclk,
   output logic      din,
   input  wire logic dout,
   input  wire logic doutOe
);
   initial begin
      csN  = 1'b1;
      sclk = 1'b1;
      din  = 1'b0;
   end

   // Command byte MSB first, then n payload bits; dout sampled at sclk rise
   // CRC of read data is the host's own business; none is expected here
   task automatic xfer(input logic [7:0] cmd, input logic [31:0] tx, input int n,
                       output logic [31:0] rx);
      rx = 32'h0;
      @(posedge clock);
      #20;
      csN = 1'b0;
      #100;
      for (int i = 0; i < 8 + n; i++) begin
         sclk = 1'b0;
         din  = (i < 8) ? cmd[7-i] : tx[n-1-(i-8)];
         #100;
         sclk = 1'b1;
         if (i >= 8) begin
            rx = {rx[30:0], dout};
         end
         #100;
      end
      csN = 1'b1;
      // Released data line shows the inverse of its last level
      din = ~din;
      #100;
   endtask : xfer

   // Select without clocking and look at the ready pin
   task automatic peek(output logic [1:0] pin);
      @(posedge clock);
      #20;
      csN = 1'b0;
      #200;
      pin = {doutOe, dout};
      csN = 1'b1;
      #100;
   endtask : peek
endmodule : adcsf_host

// File: verif/adc_status_flags_bench.sv
`timescale 1ns/1ps
module adc_status_flags_bench;
   import adcsf_pkg::*;
   logic                clock, reset_n, csN, sclk, din, dout, doutOe;
   logic                resultValid, overRange, underRange, calibMode, calibDone;
   logic                appendStatus, crcWriteErr, regCheckEn, regMismatch;
   logic [DATA_W-1:0]   resultData, dataOut;
   logic [CHAN_W-1:0]   resultChan;
   logic [STAT_W-1:0]   statusOut;
   logic [31:0]         rx;
   logic [1:0]          pin;
   int                  failCount, checksDone;

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   adcsf_status u_adcsf_status (.clock(clock), .reset_n(reset_n), .csN(csN), .sclk(sclk),
      .din(din), .dout(dout), .doutOe(doutOe), .resultValid(resultValid),
      .resultData(resultData), .resultChan(resultChan), .overRange(overRange),
      .underRange(underRange), .calibMode(calibMode), .calibDone(calibDone),
      .appendStatus(appendStatus), .crcWriteErr(crcWriteErr), .regCheckEn(regCheckEn),
      .regMismatch(regMismatch), .statusOut(statusOut), .dataOut(dataOut));

   adcsf_host u_adcsf_host (.clock(clock), .csN(csN), .sclk(sclk), .din(din),
      .dout(dout), .doutOe(doutOe));

   // ****************************************
   // Shared helpers
   // ****************************************
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checksDone++;
      if (got !== exp) begin
         failCount++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic result(input logic [23:0] d, input logic [3:0] c, input logic ov, un);
      @(negedge clock);
      resultValid = 1'b1;
      resultData  = d;
      resultChan  = c;
      overRange   = ov;
      underRange  = un;
      @(negedge clock);
      resultValid = 1'b0;
      overRange   = 1'b0;
      underRange  = 1'b0;
      repeat (3) @(negedge clock);
   endtask : result

   // Flags settle a few clocks after the frame ends, so wait before looking
   task automatic frame(input logic [7:0] cmd, input logic [31:0] tx, input int n);
      u_adcsf_host.xfer(cmd, tx, n, rx);
      repeat (4) @(negedge clock);
   endtask : frame

   task automatic printVerdict();
      $display("checks %0d failures %0d", checksDone, failCount);
      if (failCount == 0 && checksDone > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : printVerdict

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic newResultAppend();
      result(24'h123456, 4'h5, 1'b0, 1'b0);
      check("status new", 32'h05, 32'(statusOut));
      check("data new", 32'h123456, 32'(dataOut));
      u_adcsf_host.peek(pin);
      check("ready pin", 32'h2, 32'(pin));
      @(negedge clock);
      appendStatus = 1'b1;
      frame(8'h44, 32'h0, 32);
      appendStatus = 1'b0;
      check("read append", 32'h12345605, rx);
      check("status after read", 32'h85, 32'(statusOut));
      u_adcsf_host.peek(pin);
      check("ready pin idle", 32'h3, 32'(pin));
   endtask : newResultAppend

   task automatic rangeClamp();
      result(24'h00FF00, 4'hF, 1'b1, 1'b0);
      check("over data", 32'hFFFFFF, 32'(dataOut));
      check("over status", 32'h4F, 32'(statusOut));
      result(24'h00FF00, 4'h3, 1'b0, 1'b1);
      check("under data", 32'h000000, 32'(dataOut));
      check("under status", 32'h43, 32'(statusOut));
      repeat (10) @(negedge clock);
      check("range held", 32'h43, 32'(statusOut));
      result(24'h00ABCD, 4'h2, 1'b0, 1'b0);
      check("range cleared", 32'h02, 32'(statusOut));
   endtask : rangeClamp

   task automatic crcClear();
      @(negedge clock);
      crcWriteErr = 1'b1;
      @(negedge clock);
      crcWriteErr = 1'b0;
      repeat (3) @(negedge clock);
      check("crc set", 32'h22, 32'(statusOut));
      frame(8'h40, 32'h0, 8);
      check("status read crc", 32'h22, rx);
      check("crc cleared", 32'h02, 32'(statusOut));
   endtask : crcClear

   task automatic integrity();
      @(negedge clock);
      regCheckEn = 1'b1;
      regMismatch = 1'b1;
      @(negedge clock);
      regMismatch = 1'b0;
      repeat (3) @(negedge clock);
      check("integrity set", 32'h12, 32'(statusOut));
      frame(8'h40, 32'h0, 8);
      check("status read reg", 32'h12, rx);
      check("integrity kept", 32'h12, 32'(statusOut));
      regCheckEn = 1'b0;
      repeat (4) @(negedge clock);
      check("integrity off", 32'h02, 32'(statusOut));
   endtask : integrity

   task automatic writeAndOther();
      frame(8'h00, 32'hFF, 8);
      check("write ignored", 32'h02, 32'(statusOut));
      frame(8'h41, 32'h0, 8);
      check("other reg read", 32'h00, rx);
      frame(8'h44, 32'h0, 24);
      check("read no append", 32'h00ABCD, rx);
      check("ready back", 32'h82, 32'(statusOut));
   endtask : writeAndOther

   task automatic calibration();
      calibMode = 1'b1;
      result(24'h000001, 4'h7, 1'b0, 1'b0);
      check("calib no clear", 32'h1, 32'(statusOut[ST_RDY]));
      @(negedge clock);
      calibDone = 1'b1;
      @(negedge clock);
      calibDone = 1'b0;
      repeat (3) @(negedge clock);
      check("calib clear", 32'h0, 32'(statusOut[ST_RDY]));
      calibMode = 1'b0;
   endtask : calibration

   // ****************************************
   // Main sequence and watchdog
   // ****************************************
   initial begin
      {reset_n, resultValid, overRange, underRange, calibMode, calibDone} = 6'h00;
      {appendStatus, crcWriteErr, regCheckEn, regMismatch} = 4'h0;
      resultData = 24'h000000;
      resultChan = 4'h0;
      failCount  = 0;
      checksDone = 0;
      repeat (10) @(negedge clock);
      check("reset status", 32'h80, 32'(statusOut));
      check("reset pins", 32'h1, {30'h0, doutOe, dout});
      reset_n = 1'b1;
      repeat (5) @(negedge clock);
      newResultAppend();
      rangeClamp();
      crcClear();
      integrity();
      writeAndOther();
      calibration();
      printVerdict();
   end

   initial begin
      #500000;
      failCount++;
      printVerdict();
   end
endmodule : adc_status_flags_bench
